// ---- design/itr_regs.sv ----
// Identity, trim, fault-suppress and shadow-signature register bank
`timescale 1ns/1ps
// Contract
// - Serial number mirrored, read-only, writes ignored
// - Serial words ordered least significant first
// - Suppress bits exist for cells two to fourteen
// - Set bit hides cell faults, clear keeps testing
// - Cell one never hidden; mask resets zero
// - Compute 24-bit signature after each shadow load
// - Compare computed and stored signature on each scan taken while idle and not loading
// - Upper signature bytes share one register
module itr_regs
    import itr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Host register access
    input  wire itr_req_t           req,
    output logic [15:0]             rdData,
    output logic                    rdValid,
    // Nonvolatile shadow load
    input  wire logic               nvmLoad,
    input  wire itr_image_t         nvmImage,
    // Scan and comparators
    input  wire logic               scanStrobe,
    input  wire logic [13:0]        ovRaw,
    input  wire logic [13:0]        uvRaw,
    output logic [13:0]             ovFault,
    output logic [13:0]             uvFault,
    output logic                    sigMismatch,
    output logic                    sigBusy
);
    // ****************************************
    // State
    // ****************************************
    itr_image_t     shadow_reg;
    logic [15:0]    suppress_reg;
    logic [23:0]    calcSig_reg;
    itr_state_t     state_reg;
    logic [2:0]     hashIdx_reg;
    logic [15:0]    rdData_reg;
    logic           rdValid_reg;
    logic [13:0]    ovFault_reg;
    logic [13:0]    uvFault_reg;
    logic           mismatch_reg;
    logic           busy_reg;
    logic [15:0]    hashWord;
    logic [13:0]    effMask;

    // One shift of the signature register with a parallel word folded in
    function automatic logic [23:0] sigStep(input logic [23:0] sig, input logic [15:0] word);
        logic fb;
        fb = ^(sig & SIG_TAPS);
        sigStep = {sig[22:0], fb} ^ {8'h00, word};
    endfunction

    function automatic logic [15:0] readMux(input logic [8:0] a, input itr_image_t s,
                                            input logic [15:0] m, input logic [23:0] c);
        case (a)
            ADDR_SER_LOW:    readMux = s.serial[15:0];
            ADDR_SER_MID:    readMux = s.serial[31:16];
            ADDR_SER_HIGH:   readMux = s.serial[47:32];
            ADDR_TRIM:       readMux = {8'h00, s.trim};
            ADDR_SUPPRESS:   readMux = m;
            ADDR_SIG_STORED: readMux = s.storedSig[15:0];
            ADDR_SIG_CALC:   readMux = c[15:0];
            ADDR_SIG_UPPER:  readMux = {s.storedSig[23:16], c[23:16]};
            default:         readMux = READ_NONE;
        endcase
    endfunction

    // ****************************************
    // Shadow image, read only to the host
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shadow_reg <= '0;
        end else if (ce && nvmLoad) begin
            shadow_reg <= nvmImage;
        end
    end

    // ****************************************
    // Fault suppress register
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            suppress_reg <= SUPPRESS_RESET;
        end else if (ce && req.wr && req.addr == ADDR_SUPPRESS) begin
            // Cell one and reserved positions are dropped at the write
            suppress_reg <= req.wdata & SUPPRESS_WMASK;
        end
    end

    assign effMask = suppress_reg[13:0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovFault_reg <= '0;
            uvFault_reg <= '0;
        end else if (ce) begin
            ovFault_reg <= ovRaw & ~effMask;
            uvFault_reg <= uvRaw & ~effMask;
        end
    end

    // ****************************************
    // Signature engine
    // ****************************************
    always_comb begin
        case (hashIdx_reg)
            3'h0:    hashWord = shadow_reg.serial[15:0];
            3'h1:    hashWord = shadow_reg.serial[31:16];
            3'h2:    hashWord = shadow_reg.serial[47:32];
            default: hashWord = {8'h00, shadow_reg.trim};
        endcase
    end

    // A load during hashing restarts the walk so the result matches the latest image
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            busy_reg    <= 1'b0;
            hashIdx_reg <= '0;
            calcSig_reg <= SIG_SEED;
        end else if (ce) begin
            if (nvmLoad) begin
                state_reg   <= ST_HASH;
                busy_reg    <= 1'b1;
                hashIdx_reg <= '0;
                calcSig_reg <= SIG_SEED;
            end else begin
                case (state_reg)
                    ST_HASH: begin
                        calcSig_reg <= sigStep(calcSig_reg, hashWord);
                        hashIdx_reg <= hashIdx_reg + 3'h1;
                        if (hashIdx_reg == HASH_WORDS - 3'h1) begin
                            state_reg <= ST_IDLE;
                            busy_reg  <= 1'b0;
                        end
                    end
                    ST_IDLE: begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Comparison is skipped while hashing so a half-built value never flags
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mismatch_reg <= 1'b0;
        end else if (ce && scanStrobe && state_reg == ST_IDLE && !nvmLoad) begin
            mismatch_reg <= (calcSig_reg != shadow_reg.storedSig);
        end
    end

    // ****************************************
    // Host read port
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData_reg  <= READ_NONE;
            rdValid_reg <= 1'b0;
        end else if (ce) begin
            rdValid_reg <= req.rd;
            if (req.rd) begin
                rdData_reg <= readMux(req.addr, shadow_reg, suppress_reg, calcSig_reg);
            end
        end
    end

    assign rdData      = rdData_reg;
    assign rdValid     = rdValid_reg;
    assign ovFault     = ovFault_reg;
    assign uvFault     = uvFault_reg;
    assign sigMismatch = mismatch_reg;
    // Busy has its own flop so the output carries no decode glitch
    assign sigBusy     = busy_reg;

    // ****************************************
    // Checks
    // ****************************************
    AST_SERIAL_RO: assert property (@(posedge ref_clk) disable iff (rst)
        (req.wr && !(ce && nvmLoad)) |=> $stable(shadow_reg.serial))
        else $error("serial changed without a load");
    AST_SER_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && req.rd && req.addr == ADDR_SER_MID) |=> rdData == $past(shadow_reg.serial[31:16]))
        else $error("serial middle word misplaced");
    AST_RESERVED: assert property (@(posedge ref_clk) disable iff (rst)
        suppress_reg[15:14] == 2'b00 && suppress_reg[0] == 1'b0)
        else $error("reserved suppress bits set");
    AST_CELL1_KEPT: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && ovRaw[0]) |=> ovFault[0])
        else $error("cell one fault hidden");
    AST_MASK_HIDES: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && suppress_reg[5]) |=> !ovFault[5] && !uvFault[5])
        else $error("suppressed cell still faults");
    AST_UNMASK_TESTS: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && !suppress_reg[5] && uvRaw[5]) |=> uvFault[5])
        else $error("unsuppressed fault lost");
    AST_HASH_LEN: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && nvmLoad) ##1 (ce && !nvmLoad) [*4] |=> !sigBusy)
        else $error("signature walk length wrong");
    AST_SCAN_CMP: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && scanStrobe && !sigBusy && !nvmLoad)
        |=> sigMismatch == ($past(calcSig_reg) != $past(shadow_reg.storedSig)))
        else $error("scan comparison wrong");
    AST_SIG_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && req.rd && req.addr == ADDR_SIG_CALC) |=> rdData == $past(calcSig_reg[15:0]))
        else $error("computed low half wrong");
    AST_SIG_UPPER: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && req.rd && req.addr == ADDR_SIG_UPPER)
        |=> rdData == {$past(shadow_reg.storedSig[23:16]), $past(calcSig_reg[23:16])})
        else $error("upper signature bytes wrong");
    AST_TRIM_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && req.rd && req.addr == ADDR_TRIM) |=> rdData[15:8] == 8'h00)
        else $error("trim reserved bits nonzero");
endmodule

// ---- design/itr_pkg.sv ----
// Constants and carrier types for the identity, trim and integrity register bank
package itr_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam int          ADDR_W          = 9;
    localparam int          DATA_W          = 16;
    localparam int          CELLS           = 14;
    localparam logic [8:0]  ADDR_SER_LOW    = 9'h097;
    localparam logic [8:0]  ADDR_SER_MID    = 9'h098;
    localparam logic [8:0]  ADDR_SER_HIGH   = 9'h099;
    localparam logic [8:0]  ADDR_TRIM       = 9'h09a;
    localparam logic [8:0]  ADDR_SUPPRESS   = 9'h09b;
    localparam logic [8:0]  ADDR_SIG_STORED = 9'h09c;
    localparam logic [8:0]  ADDR_SIG_CALC   = 9'h09d;
    localparam logic [8:0]  ADDR_SIG_UPPER  = 9'h09e;

    // ****************************************
    // Field layouts and reset values
    // ****************************************
    localparam logic [15:0] SUPPRESS_RESET  = 16'h0000;
    localparam logic [15:0] SUPPRESS_WMASK  = 16'h3ffe;
    localparam logic [15:0] READ_NONE       = 16'h0000;
    localparam logic [23:0] SIG_SEED        = 24'h00_0000;
    localparam logic [23:0] SIG_TAPS        = 24'h83_0000;
    localparam logic [2:0]  HASH_WORDS      = 3'h4;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic               rd;
        logic               wr;
        logic [8:0]         addr;
        logic [15:0]        wdata;
    } itr_req_t;

    typedef struct packed {
        logic [47:0]        serial;
        logic [7:0]         trim;
        logic [23:0]        storedSig;
    } itr_image_t;

    typedef enum logic {ST_IDLE, ST_HASH} itr_state_t;
endpackage

// ---- dv/itr_host.sv ----
// Host-side model that issues register reads and writes to the bank
`timescale 1ns/1ps
module itr_host
    import itr_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Register access
    output itr_req_t         req,
    input  wire logic [15:0] rdData,
    input  wire logic        rdValid
);
    initial req = '0;

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask

    // Strobe is held for one taken edge; the answer is awaited under a bound
    task automatic rd(input logic [8:0] a, output logic [15:0] d, output bit ok);
        @(posedge ref_clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        req <= '0;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rdValid === 1'b1) ok = 1'b1;
            else @(posedge ref_clk);
        end
        d = rdData;
    endtask

    // Software integrity check over both signature copies
    task automatic sig_equal(output bit eq);
        logic [15:0] s, c, u;
        bit          ok;
        rd(ADDR_SIG_STORED, s, ok);
        rd(ADDR_SIG_CALC, c, ok);
        rd(ADDR_SIG_UPPER, u, ok);
        eq = (s === c) && (u[15:8] === u[7:0]);
    endtask
endmodule

// ---- dv/identity_trim_integrity_regs_bench.sv ----
// Self-checking bench for the identity, trim and integrity register bank
`timescale 1ns/1ps
module identity_trim_integrity_regs_bench
    import itr_pkg::*;
;
    logic        ref_clk, rst, ce, rdValid, nvmLoad, scanStrobe, sigMismatch, sigBusy;
    itr_req_t    req;
    logic [15:0] rdData;
    itr_image_t  nvmImage, img;
    logic [13:0] ovRaw, uvRaw, ovFault, uvFault;
    int          failures, nChecks;

    itr_regs u_itr_regs (.ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req), .rdData(rdData),
        .rdValid(rdValid), .nvmLoad(nvmLoad), .nvmImage(nvmImage), .scanStrobe(scanStrobe),
        .ovRaw(ovRaw), .uvRaw(uvRaw), .ovFault(ovFault), .uvFault(uvFault),
        .sigMismatch(sigMismatch), .sigBusy(sigBusy));
    itr_host u_itr_host (.ref_clk(ref_clk), .req(req), .rdData(rdData), .rdValid(rdValid));

    // Independent signature model, seed zero, words low serial first
    function automatic logic [23:0] sigModel(input itr_image_t im);
        logic [23:0] s;
        logic [15:0] w [4];
        w = '{im.serial[15:0], im.serial[31:16], im.serial[47:32], {8'h00, im.trim}};
        s = 24'h00_0000;
        for (int i = 0; i < 4; i++) s = {s[22:0], s[23] ^ s[17] ^ s[16]} ^ {8'h00, w[i]};
        return s;
    endfunction

    task automatic summarize();
        if (failures == 0 && nChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [8:0] a, input logic [15:0] exp);
        logic [15:0] d;
        bit          ok;
        u_itr_host.rd(a, d, ok);
        if (!ok) begin
            chk(16'hdead, 16'h0000);
            summarize();
        end
        chk(d, exp);
    endtask

    task automatic t_load_scan(input itr_image_t im, input logic bad);
        logic [23:0] c;
        int          n;
        bit          eq;
        c = sigModel(im);
        @(posedge ref_clk);
        nvmLoad  <= 1'b1;
        nvmImage <= im;
        @(posedge ref_clk);
        nvmLoad  <= 1'b0;
        #1;
        n = 0;
        while (sigBusy === 1'b1 && n < 10) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
        chk(16'(n), 16'h0004);
        if (n >= 10) summarize();
        rchk(ADDR_SER_LOW, im.serial[15:0]);
        u_itr_host.wr(ADDR_SER_MID, ~im.serial[31:16]);
        rchk(ADDR_SER_MID, im.serial[31:16]);
        rchk(ADDR_SER_HIGH, im.serial[47:32]);
        rchk(ADDR_TRIM, {8'h00, im.trim});
        rchk(ADDR_SIG_STORED, im.storedSig[15:0]);
        rchk(ADDR_SIG_CALC, c[15:0]);
        rchk(ADDR_SIG_UPPER, {im.storedSig[23:16], c[23:16]});
        rchk(9'h0a0, 16'h0000);
        @(posedge ref_clk);
        scanStrobe <= 1'b1;
        @(posedge ref_clk);
        scanStrobe <= 1'b0;
        #1;
        chk({15'h0000, sigMismatch}, {15'h0000, bad});
        u_itr_host.sig_equal(eq);
        chk({15'h0000, eq}, {15'h0000, !bad});
    endtask

    // Out of reset the mask is clear, so every raw fault shows
    task automatic t_reset_state();
        rchk(ADDR_SUPPRESS, 16'h0000);
        chk({2'h0, ovFault}, 16'h3fff);
        chk({15'h0000, sigBusy}, 16'h0000);
    endtask

    // Mask write, then raw patterns seen through it one cycle later
    task automatic t_mask(input logic [15:0] w, input logic [13:0] ov, input logic [13:0] uv);
        logic [13:0] keep;
        keep = ~(w[13:0] & 14'h3ffe);
        u_itr_host.wr(ADDR_SUPPRESS, w);
        rchk(ADDR_SUPPRESS, w & 16'h3ffe);
        @(posedge ref_clk);
        ovRaw <= ov;
        uvRaw <= uv;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({2'h0, ovFault}, {2'h0, ov & keep});
        chk({2'h0, uvFault}, {2'h0, uv & keep});
    endtask

    // With the enable low a write, a load and a scan must all be dropped
    task automatic t_freeze();
        @(posedge ref_clk);
        ce         <= 1'b0;
        nvmLoad    <= 1'b1;
        scanStrobe <= 1'b1;
        nvmImage   <= '0;
        @(posedge ref_clk);
        nvmLoad    <= 1'b0;
        scanStrobe <= 1'b0;
        u_itr_host.wr(ADDR_SUPPRESS, 16'h3ffe);
        #1;
        chk({15'h0000, sigBusy}, 16'h0000);
        @(posedge ref_clk);
        ce <= 1'b1;
        rchk(ADDR_SUPPRESS, 16'h0000);
        rchk(ADDR_SER_LOW, 16'h7654);
        chk({15'h0000, sigMismatch}, 16'h0001);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        nvmLoad = 1'b0;
        nvmImage = '0;
        scanStrobe = 1'b0;
        ovRaw = 14'h3fff;
        uvRaw = 14'h3fff;
        failures = 0;
        nChecks = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_state();
        img = '{serial: 48'h1234_5678_9abc, trim: 8'h2a, storedSig: 24'h00_0000};
        img.storedSig = sigModel(img);
        t_load_scan(img, 1'b0);
        img = '{serial: 48'hfedc_ba98_7654, trim: 8'hc3, storedSig: 24'h00_0000};
        img.storedSig = sigModel(img) ^ 24'h01_0001;
        t_load_scan(img, 1'b1);
        t_mask(16'hffff, 14'h3fff, 14'h3fff);
        t_mask(16'h0004, 14'h2aaf, 14'h1555);
        t_mask(16'h0000, 14'h1550, 14'h2aaa);
        t_freeze();
        summarize();
    end
endmodule
